// [core/dsr_consts.svh]
/*
  Register offsets, field positions, reset values and counts of the drawing
  engine setup register bank. Assumes inclusion by bare name from core/.
*/
`ifndef DSR_CONSTS_SVH
`define DSR_CONSTS_SVH

`define DSR_OFF_DRAW_CTRL 14'h1C00
`define DSR_OFF_MEM_SETUP 14'h1C04
`define DSR_OFF_FG_COLOR 14'h1C24
`define DSR_OFF_DRAW_COUNT 14'h1C5C
`define DSR_OFF_X_BOUNDS 14'h1C84
`define DSR_OFF_LEFT_X 14'h1CA8
`define DSR_OFF_RIGHT_X 14'h1CAC
`define DSR_OFF_QSTATUS 14'h1E10
`define DSR_OFF_INT_CLEAR 14'h1E18
`define DSR_OFF_INT_ENABLE 14'h1E1C

`define DSR_CTL_PATTERN 29
`define DSR_CTL_TRANSC 30
`define DSR_CTL_BLTMOD_HI 28
`define DSR_CTL_BLTMOD_LO 25
`define DSR_CTL_ATYPE_HI 6
`define DSR_CTL_ATYPE_LO 4
`define DSR_CTL_OPCOD_HI 3
`define DSR_CTL_OPCOD_LO 0
`define DSR_OPCOD_BITBLT 4'h8
`define DSR_BLTMOD_COLOR 4'h2
`define DSR_ATYPE_BLOCK 3'h4

`define DSR_MA_MEMRESET 15
`define DSR_MA_NODITHER 30
`define DSR_MA_FMT555 31
`define DSR_PW_8 2'h0
`define DSR_PW_16 2'h1
`define DSR_PW_32 2'h2
`define DSR_PW_24 2'h3

`define DSR_QS_FULL 8
`define DSR_QS_EMPTY 9
`define DSR_INT_PICK 2
`define DSR_INT_VLINE 5
`define DSR_INT_EXT 6

`define DSR_Q_DEPTH 32
`define DSR_Q_CW 6
`define DSR_RETRY_LIMIT 16
`define DSR_RESET_WORD 32'h0000_0000

`endif

// [core/dsr_pkg.sv]
/*
  Types of the drawing engine setup register bank.
  Assumes the constants header sits beside it.
*/
package dsr_pkg;

  typedef struct packed {
    logic wr;
    logic [13:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } dsr_hreq_type;

  typedef struct packed {
    logic [13:0] addr;
    logic [31:0] data;
  } dsr_qent_type;

  typedef struct packed {
    logic pattern_en;
    logic bg_transparent;
    logic fast_clip;
    logic [3:0] opcode;
    logic [3:0] blt_mode;
    logic [2:0] access_type;
    logic [1:0] pix_size;
    logic dither_en;
    logic format_555;
    logic [15:0] draw_count;
    logic [15:0] left_x;
    logic [15:0] right_x;
    logic [31:0] expand_color;
    logic [7:0] alpha;
  } dsr_cfg_type;

  typedef enum logic [1:0] {HS_IDLE, HS_ANSWER, HS_RELEASE} dsr_hst_type;

endpackage

// [core/dsr_wqueue.sv]
/*
  Host write queue: a flushable FIFO that reports its free locations.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`include "dsr_consts.svh"
module dsr_wqueue #(
  parameter int WIDTH = 46,
  parameter int DEPTH = `DSR_Q_DEPTH,
  parameter int CW = `DSR_Q_CW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] free
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] used_q;
  logic push;
  logic pop;

  assign in_ready = used_q != CW'(DEPTH);
  assign out_valid = used_q != '0;
  assign out_data = mem_q[rp_q];
  assign free = CW'(DEPTH) - used_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // A flush drops every entry, so the free count returns to the full depth.
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wp_q <= '0;
      rp_q <= '0;
      used_q <= '0;
    end else begin
      if (push) begin
        wp_q <= AW'(wp_q + 1'b1);
      end
      if (pop) begin
        rp_q <= AW'(rp_q + 1'b1);
      end
      used_q <= CW'(used_q + CW'(push) - CW'(pop));
    end
  end

  a_flush_count: assert property (@(posedge clk) disable iff (!rst_n)
    flush |=> free == CW'(DEPTH)) else $error("queue not emptied by flush");
  a_empty_msb: assert property (@(posedge clk) disable iff (!rst_n)
    (!out_valid) == free[CW-1]) else $error("empty flag differs from count msb");
endmodule

// [core/dsr_setup_regs.sv]
/*
  Setup register bank of the drawing engine: queued drawing registers,
  queue status, interrupt clear and enable, and the pci interrupt pin.
  Assumes a host-cycle port already decoded from pci memory cycles, an
  engine that drains the queue on the same clock, and asynchronous
  pick and external interrupt pins.
*/
// What this block does
// - Patterning bit enables patterning for block transfers.
// - Background transparency bit makes background pixels transparent when set.
// - Screen copy with colour source format turns on fast clipping.
// - Foreground colour feeds expansion; top byte dropped at 24 bpp unless block.
// - Shading alpha comes from the foreground colour top bits at 32 bpp and 5:5:5 16 bpp; zero otherwise.
// - Free slot count reports free queue places; reset flushes to 32.
// - Full flag when queue full; empty flag equals count bit 5.
// - Writes into a full queue get retries until space or limit.
// - Queue status is sampled at read start and held for the read.
// - Bounds pair write loads left from low and right from high half.
// - Left edge is a signed 16-bit value, updated by left edge scan.
// - Right edge is updated by right edge scan, static for transfers.
// - Writing one to clear bits 2 or 5 drops pick or vline pending.
// - Vline enable raises an interrupt when line counter meets target.
// - External enable lets the external input drive the interrupt pin.
// - Draw count is 16-bit unsigned pixel or line count.
// - Pixel size 00, 01, 10, 11 select 8, 16, 32, 24 bpp.
// - Memory reset bit makes exactly one frame memory reset cycle.
// - Dither off bit clear enables dithering, set disables it.
// - Format bit picks 5:6:5 or 5:5:5 for 16 bpp.
`timescale 1ns/100ps
`include "dsr_consts.svh"
module dsr_setup_regs #(
  parameter int RETRY_LIMIT = `DSR_RETRY_LIMIT
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic SOFT_RESET,
  input wire logic HOST_REQ,
  input dsr_pkg::dsr_hreq_type HOST_CMD,
  output logic HOST_ACK,
  output logic HOST_RETRY,
  output logic HOST_ABORT,
  output logic [31:0] HOST_RDATA,
  input wire logic ENG_READY,
  input wire logic ENG_XLEFT_WE,
  input wire logic [15:0] ENG_XLEFT,
  input wire logic ENG_XRIGHT_WE,
  input wire logic [15:0] ENG_XRIGHT,
  input wire logic PICK_EVENT,
  input wire logic EXT_INT,
  input wire logic [11:0] VLINE_COUNT,
  input wire logic [11:0] VLINE_TARGET,
  output dsr_pkg::dsr_cfg_type ENG_CFG,
  output logic MEM_RESET_PULSE,
  output logic PCI_INTA_N
);
  import dsr_pkg::*;

  dsr_hst_type state_q;
  dsr_hreq_type req_q;
  logic [31:0] rdata_q;
  logic [7:0] retry_cnt_q;
  logic [31:0] ctl_q;
  logic [31:0] macc_q;
  logic [31:0] foreground_color_q;
  logic [15:0] len_q;
  logic [15:0] left_q;
  logic [15:0] right_q;
  logic [2:0] ien_q;
  logic pick_pend_q;
  logic vline_pend_q;
  logic memrst_q;
  logic inta_q;
  logic [2:0] pick_sync_q;
  logic [1:0] ext_sync_q;
  logic vmatch_q;
  logic queued_reg;
  logic q_push;
  logic q_ready;
  logic q_valid;
  logic q_pop;
  logic [5:0] q_free;
  dsr_qent_type q_in;
  dsr_qent_type q_out;
  logic answering;
  logic wr_direct;
  logic pick_set;
  logic vline_set;
  logic pick_clr;
  logic vline_clr;
  logic vmatch;
  logic limit_hit;
  logic [31:0] stat_word;
  logic [31:0] ien_word;

  assign queued_reg = req_q.addr == `DSR_OFF_DRAW_CTRL
                   || req_q.addr == `DSR_OFF_MEM_SETUP
                   || req_q.addr == `DSR_OFF_FG_COLOR
                   || req_q.addr == `DSR_OFF_DRAW_COUNT
                   || req_q.addr == `DSR_OFF_X_BOUNDS
                   || req_q.addr == `DSR_OFF_LEFT_X
                   || req_q.addr == `DSR_OFF_RIGHT_X;
  assign answering = state_q == HS_ANSWER;
  assign limit_hit = retry_cnt_q >= 8'(RETRY_LIMIT);
  assign q_push = answering && req_q.wr && queued_reg && q_ready;
  assign wr_direct = answering && req_q.wr && req_q.be[0];
  assign q_in = '{addr: req_q.addr, data: req_q.wdata};
  assign q_pop = q_valid && ENG_READY;

  // Only queued writes wait on space; reads and direct registers never retry.
  assign HOST_RETRY = answering && req_q.wr && queued_reg && !q_ready && !limit_hit;
  assign HOST_ABORT = answering && req_q.wr && queued_reg && !q_ready && limit_hit;
  assign HOST_ACK = answering && !(req_q.wr && queued_reg && !q_ready);
  assign HOST_RDATA = rdata_q;

  dsr_wqueue #(
    .WIDTH($bits(dsr_qent_type)),
    .DEPTH(`DSR_Q_DEPTH),
    .CW(`DSR_Q_CW)
  ) u_queue (
    .clk(MCLK),
    .rst_n(NRST),
    .flush(SOFT_RESET),
    .in_valid(q_push),
    .in_ready(q_ready),
    .in_data(q_in),
    .out_valid(q_valid),
    .out_ready(ENG_READY),
    .out_data(q_out),
    .free(q_free)
  );

  always_comb begin
    stat_word = '0;
    stat_word[5:0] = q_free;
    stat_word[`DSR_QS_FULL] = !q_ready;
    stat_word[`DSR_QS_EMPTY] = q_free[5];
    ien_word = '0;
    ien_word[`DSR_INT_PICK] = ien_q[0];
    ien_word[`DSR_INT_VLINE] = ien_q[1];
    ien_word[`DSR_INT_EXT] = ien_q[2];
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      state_q <= HS_IDLE;
    end else begin
      unique case (state_q)
        HS_IDLE: begin
          if (HOST_REQ) begin
            state_q <= HS_ANSWER;
          end
        end
        HS_ANSWER: begin
          state_q <= HS_RELEASE;
        end
        HS_RELEASE: begin
          if (!HOST_REQ) begin
            state_q <= HS_IDLE;
          end
        end
      endcase
    end
  end

  // The status word is caught once as the cycle opens, so a queue that
  // drains mid-read never tears the value the host sees.
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      req_q <= '0;
      rdata_q <= `DSR_RESET_WORD;
    end else if (state_q == HS_IDLE && HOST_REQ) begin
      req_q <= HOST_CMD;
      if (HOST_CMD.wr) begin
        rdata_q <= `DSR_RESET_WORD;
      end else if (HOST_CMD.addr == `DSR_OFF_QSTATUS) begin
        rdata_q <= stat_word;
      end else if (HOST_CMD.addr == `DSR_OFF_INT_ENABLE) begin
        rdata_q <= ien_word;
      end else begin
        rdata_q <= `DSR_RESET_WORD;
      end
    end
  end

  // A stuck engine would retry forever; past the limit the write is aborted.
  always_ff @(posedge MCLK) begin
    if (!NRST || SOFT_RESET) begin
      retry_cnt_q <= '0;
    end else if (HOST_RETRY) begin
      retry_cnt_q <= 8'(retry_cnt_q + 1'b1);
    end else if (HOST_ABORT || q_push) begin
      retry_cnt_q <= '0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      ctl_q <= `DSR_RESET_WORD;
      macc_q <= `DSR_RESET_WORD;
      foreground_color_q <= `DSR_RESET_WORD;
      len_q <= '0;
    end else if (q_pop) begin
      unique case (q_out.addr)
        `DSR_OFF_DRAW_CTRL: ctl_q <= q_out.data;
        `DSR_OFF_MEM_SETUP: macc_q <= q_out.data;
        `DSR_OFF_FG_COLOR: foreground_color_q <= q_out.data;
        `DSR_OFF_DRAW_COUNT: len_q <= q_out.data[15:0];
        default: len_q <= len_q;
      endcase
    end
  end

  // Host loads win over an engine scan update in the same cycle.
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      left_q <= '0;
    end else if (q_pop && (q_out.addr == `DSR_OFF_X_BOUNDS || q_out.addr == `DSR_OFF_LEFT_X)) begin
      left_q <= q_out.data[15:0];
    end else if (ENG_XLEFT_WE) begin
      left_q <= ENG_XLEFT;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      right_q <= '0;
    end else if (q_pop && q_out.addr == `DSR_OFF_X_BOUNDS) begin
      right_q <= q_out.data[31:16];
    end else if (q_pop && q_out.addr == `DSR_OFF_RIGHT_X) begin
      right_q <= q_out.data[15:0];
    end else if (ENG_XRIGHT_WE) begin
      right_q <= ENG_XRIGHT;
    end
  end

  // One pulse per accepted setup word with the bit set, never a level.
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      memrst_q <= 1'b0;
    end else begin
      memrst_q <= q_pop && q_out.addr == `DSR_OFF_MEM_SETUP && q_out.data[`DSR_MA_MEMRESET];
    end
  end
  assign MEM_RESET_PULSE = memrst_q;

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      ENG_CFG <= '0;
    end else begin
      ENG_CFG.pattern_en <= ctl_q[`DSR_CTL_PATTERN];
      ENG_CFG.bg_transparent <= ctl_q[`DSR_CTL_TRANSC];
      ENG_CFG.opcode <= ctl_q[`DSR_CTL_OPCOD_HI:`DSR_CTL_OPCOD_LO];
      ENG_CFG.blt_mode <= ctl_q[`DSR_CTL_BLTMOD_HI:`DSR_CTL_BLTMOD_LO];
      ENG_CFG.access_type <= ctl_q[`DSR_CTL_ATYPE_HI:`DSR_CTL_ATYPE_LO];
      ENG_CFG.fast_clip <= ctl_q[`DSR_CTL_OPCOD_HI:`DSR_CTL_OPCOD_LO] == `DSR_OPCOD_BITBLT
        && ctl_q[`DSR_CTL_BLTMOD_HI:`DSR_CTL_BLTMOD_LO] == `DSR_BLTMOD_COLOR;
      ENG_CFG.pix_size <= macc_q[1:0];
      ENG_CFG.dither_en <= !macc_q[`DSR_MA_NODITHER];
      ENG_CFG.format_555 <= macc_q[`DSR_MA_FMT555];
      ENG_CFG.draw_count <= len_q;
      ENG_CFG.left_x <= left_q;
      ENG_CFG.right_x <= right_q;
      // One process drives the whole carrier; at 24 bpp the unused top byte is masked unless the access type is block.
      if (macc_q[1:0] == `DSR_PW_24 && ctl_q[`DSR_CTL_ATYPE_HI:`DSR_CTL_ATYPE_LO] != `DSR_ATYPE_BLOCK) begin
        ENG_CFG.expand_color <= {8'h00, foreground_color_q[23:0]};
      end else begin
        ENG_CFG.expand_color <= foreground_color_q;
      end
      if (macc_q[1:0] == `DSR_PW_32) begin
        ENG_CFG.alpha <= foreground_color_q[31:24];
      end else if (macc_q[1:0] == `DSR_PW_16 && macc_q[`DSR_MA_FMT555]) begin
        ENG_CFG.alpha <= {foreground_color_q[31], 7'h00};
      end else begin
        ENG_CFG.alpha <= 8'h00;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      ien_q <= '0;
    end else if (wr_direct && req_q.addr == `DSR_OFF_INT_ENABLE) begin
      ien_q <= {req_q.wdata[`DSR_INT_EXT], req_q.wdata[`DSR_INT_VLINE], req_q.wdata[`DSR_INT_PICK]};
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      pick_sync_q <= '0;
      ext_sync_q <= '0;
      vmatch_q <= 1'b0;
    end else begin
      pick_sync_q <= {pick_sync_q[1:0], PICK_EVENT};
      ext_sync_q <= {ext_sync_q[0], EXT_INT};
      vmatch_q <= vmatch;
    end
  end

  assign vmatch = VLINE_COUNT == VLINE_TARGET;
  assign pick_set = pick_sync_q[1] && !pick_sync_q[2];
  assign vline_set = vmatch && !vmatch_q;
  assign pick_clr = wr_direct && req_q.addr == `DSR_OFF_INT_CLEAR && req_q.wdata[`DSR_INT_PICK];
  assign vline_clr = wr_direct && req_q.addr == `DSR_OFF_INT_CLEAR && req_q.wdata[`DSR_INT_VLINE];

  // A new event in the clearing cycle keeps its flag set.
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      pick_pend_q <= 1'b0;
    end else if (pick_set) begin
      pick_pend_q <= 1'b1;
    end else if (pick_clr) begin
      pick_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      vline_pend_q <= 1'b0;
    end else if (vline_set) begin
      vline_pend_q <= 1'b1;
    end else if (vline_clr) begin
      vline_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      inta_q <= 1'b0;
    end else begin
      inta_q <= (pick_pend_q && ien_q[0])
             || (vline_pend_q && ien_q[1])
             || (ext_sync_q[1] && ien_q[2]);
    end
  end
  assign PCI_INTA_N = !inta_q;

  a_retry_when_full: assert property (@(posedge MCLK) disable iff (!NRST)
    answering && req_q.wr && queued_reg && q_free == 6'h00 && retry_cnt_q < 8'(RETRY_LIMIT)
    |-> HOST_RETRY && !HOST_ACK && !HOST_ABORT && !q_push) else $error("full queue write not retried");
  a_status_held: assert property (@(posedge MCLK) disable iff (!NRST)
    state_q == HS_RELEASE |-> $stable(HOST_RDATA)) else $error("read data moved in cycle");
  a_status_sample: assert property (@(posedge MCLK) disable iff (!NRST)
    state_q == HS_IDLE && HOST_REQ && !HOST_CMD.wr && HOST_CMD.addr == `DSR_OFF_QSTATUS
    |=> HOST_RDATA == {22'h0, $past(q_free[5]), $past(q_free) == 6'h00, 2'h0, $past(q_free)})
    else $error("status not sampled at read start");
  a_bounds_load: assert property (@(posedge MCLK) disable iff (!NRST)
    q_pop && q_out.addr == `DSR_OFF_X_BOUNDS |=> right_q == $past(q_out.data[31:16])
    && left_q == $past(q_out.data[15:0])) else $error("bounds pair split wrong");
  a_memrst_single: assert property (@(posedge MCLK) disable iff (!NRST)
    MEM_RESET_PULSE |=> !MEM_RESET_PULSE || $past(q_pop) && $past(q_out.data[`DSR_MA_MEMRESET]))
    else $error("memory reset longer than one write");
  a_pick_set_wins: assert property (@(posedge MCLK) disable iff (!NRST)
    pick_set |=> pick_pend_q) else $error("pick event lost");
  a_pick_clear: assert property (@(posedge MCLK) disable iff (!NRST)
    pick_clr && !pick_set |=> !pick_pend_q) else $error("pick pending not cleared");
  a_irq_pin: assert property (@(posedge MCLK) disable iff (!NRST)
    pick_pend_q && ien_q[0] |=> !PCI_INTA_N) else $error("enabled pick not on pin");
  a_irq_quiet: assert property (@(posedge MCLK) disable iff (!NRST)
    ien_q == 3'h0 |=> PCI_INTA_N) else $error("pin asserted with no enable");
  a_fast_clip: assert property (@(posedge MCLK) disable iff (!NRST)
    ENG_CFG.fast_clip == (ENG_CFG.opcode == `DSR_OPCOD_BITBLT && ENG_CFG.blt_mode == `DSR_BLTMOD_COLOR))
    else $error("fast clip not tied to color blit");
  a_mask_24bpp: assert property (@(posedge MCLK) disable iff (!NRST)
    ENG_CFG.pix_size == `DSR_PW_24 && $stable(ENG_CFG.pix_size) && $stable(macc_q)
    && $stable(ctl_q) && ENG_CFG.access_type != `DSR_ATYPE_BLOCK
    |-> ENG_CFG.expand_color[31:24] == 8'h00) else $error("top byte used at 24 bpp");
endmodule

// [test/dsr_host_model.sv]
/*
  Host processor model: issues decoded memory cycles to the setup register bank.
  Assumes it shares the bank's clock and that its requests start at a falling edge.
*/
`timescale 1ns/100ps
module dsr_host_model (
  input wire logic clk,
  output logic req,
  output dsr_pkg::dsr_hreq_type cmd,
  input wire logic ack,
  input wire logic retry,
  input wire logic abort,
  input wire logic [31:0] rdata
);
  import dsr_pkg::*;

  initial begin
    req = 1'b0;
    cmd = '0;
  end

  // Response codes: 0 completed, 1 retry, 2 abort, 3 no answer.
  task automatic cycle(input logic is_wr, input logic [13:0] addr, input logic [31:0] data,
                       output logic [1:0] resp, output logic [31:0] rd);
    int n;
    n = 0;
    resp = 2'h3;
    rd = 32'h0;
    @(negedge clk);
    req = 1'b1;
    cmd = '{wr: is_wr, addr: addr, be: 4'hF, wdata: data};
    while (resp == 2'h3 && n < 8) begin
      @(negedge clk);
      n++;
      if (ack === 1'b1) begin
        resp = 2'h0;
        rd = rdata;
      end else if (retry === 1'b1) begin
        resp = 2'h1;
      end else if (abort === 1'b1) begin
        resp = 2'h2;
      end
    end
    @(posedge clk);
    @(negedge clk);
    // A released bus must not keep showing the old command.
    req = 1'b0;
    cmd = ~cmd;
    // Return on a falling edge so the caller's next drive never races a rising edge.
    @(negedge clk);
  endtask

  // A refused write is offered again until it is taken or dropped, or until it has been retried 40 times.
  task automatic write(input logic [13:0] addr, input logic [31:0] data, output logic [1:0] resp,
                       output int retries);
    logic [31:0] rd;
    retries = 0;
    cycle(1'b1, addr, data, resp, rd);
    while (resp == 2'h1 && retries < 40) begin
      retries++;
      cycle(1'b1, addr, data, resp, rd);
    end
  endtask
endmodule

// [test/dsr_setup_regs_tb.sv]
/*
  Self-checking bench of the setup register bank, one task per scenario.
  Assumes the host model beside it and the design and its header under core/.
*/
`timescale 1ns/100ps
`include "dsr_consts.svh"
module dsr_setup_regs_tb;
  import dsr_pkg::*;
  localparam int LIMIT = 2;
  logic mclk, nrst, soft_reset, eng_ready, xl_we, xr_we, pick, ext;
  logic [15:0] xl, xr;
  logic [11:0] vcnt, vtgt;
  logic host_req, ack, retry, abort, mrst, inta_n;
  logic [31:0] rdata;
  dsr_hreq_type cmd;
  dsr_cfg_type cfg;
  int err_count, check_count, cycles, pulses;

  dsr_setup_regs #(.RETRY_LIMIT(LIMIT)) dut (.MCLK(mclk), .NRST(nrst), .SOFT_RESET(soft_reset),
    .HOST_REQ(host_req), .HOST_CMD(cmd), .HOST_ACK(ack), .HOST_RETRY(retry), .HOST_ABORT(abort),
    .HOST_RDATA(rdata), .ENG_READY(eng_ready), .ENG_XLEFT_WE(xl_we), .ENG_XLEFT(xl),
    .ENG_XRIGHT_WE(xr_we), .ENG_XRIGHT(xr), .PICK_EVENT(pick), .EXT_INT(ext), .VLINE_COUNT(vcnt),
    .VLINE_TARGET(vtgt), .ENG_CFG(cfg), .MEM_RESET_PULSE(mrst), .PCI_INTA_N(inta_n));
  dsr_host_model host (.clk(mclk), .req(host_req), .cmd(cmd), .ack(ack), .retry(retry),
    .abort(abort), .rdata(rdata));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (mrst === 1'b1) pulses++;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic [1:0] r;
    int n;
    host.write(a, d, r, n);
    chk({30'h0, r}, 32'h0, "write answer");
    repeat (4) @(negedge mclk);
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] exp, input string what);
    logic [1:0] r;
    logic [31:0] d;
    host.cycle(1'b0, a, 32'h0, r, d);
    chk(d, exp, what);
  endtask

  task automatic t_reset();
    rd(`DSR_OFF_QSTATUS, 32'h0000_0220, "status after reset");
    rd(`DSR_OFF_INT_ENABLE, 32'h0, "enable after reset");
    rd(14'h1E00, 32'h0, "unmapped read");
    chk({31'h0, inta_n}, 32'h1, "pin idle");
  endtask

  task automatic t_control();
    wr(`DSR_OFF_DRAW_CTRL, 32'h0400_0000);
    chk({31'h0, cfg.fast_clip}, 32'h0, "styled line no clip");
    wr(`DSR_OFF_DRAW_CTRL, 32'h6400_0008);
    chk({29'h0, cfg.pattern_en, cfg.bg_transparent, cfg.fast_clip}, 32'h7, "ctl on");
    chk({21'h0, cfg.opcode, cfg.blt_mode, cfg.access_type}, 32'h0000_0410, "ctl fields");
    wr(`DSR_OFF_DRAW_CTRL, 32'h0000_0008);
    chk({29'h0, cfg.pattern_en, cfg.bg_transparent, cfg.fast_clip}, 32'h0, "ctl off");
  endtask

  task automatic t_setup();
    for (int p = 0; p < 4; p++) begin
      wr(`DSR_OFF_MEM_SETUP, {p[1], p[0], 14'h0, (p == 0), 13'h0, p[1:0]});
      chk({28'h0, cfg.pix_size, cfg.dither_en, cfg.format_555}, {28'h0, p[1:0], ~p[0], p[1]},
          "setup fields");
    end
    chk(32'(pulses), 32'h1, "memory reset pulses");
  endtask

  task automatic t_color();
    wr(`DSR_OFF_MEM_SETUP, 32'h0000_0003);
    wr(`DSR_OFF_FG_COLOR, 32'hA1B2_C3D4);
    chk(cfg.expand_color, 32'h00B2_C3D4, "24bpp colour");
    wr(`DSR_OFF_DRAW_CTRL, 32'h0000_0040);
    chk(cfg.expand_color, 32'hA1B2_C3D4, "block colour");
    wr(`DSR_OFF_MEM_SETUP, 32'h0000_0002);
    chk({24'h0, cfg.alpha}, 32'h0000_00A1, "32bpp alpha");
    wr(`DSR_OFF_MEM_SETUP, 32'h8000_0001);
    chk({24'h0, cfg.alpha}, 32'h0000_0080, "555 alpha");
  endtask

  task automatic t_geometry();
    wr(`DSR_OFF_DRAW_COUNT, 32'hABCD_1234);
    chk({16'h0, cfg.draw_count}, 32'h0000_1234, "count");
    wr(`DSR_OFF_X_BOUNDS, 32'h8001_7FFF);
    chk({cfg.right_x, cfg.left_x}, 32'h8001_7FFF, "bounds pair");
    wr(`DSR_OFF_LEFT_X, 32'hFFFF_FFF0);
    wr(`DSR_OFF_RIGHT_X, 32'h0000_0040);
    chk({cfg.right_x, cfg.left_x}, 32'h0040_FFF0, "edges");
    xl = 16'h0123;
    xr = 16'h0456;
    xl_we = 1'b1;
    xr_we = 1'b1;
    @(negedge mclk);
    xl_we = 1'b0;
    xr_we = 1'b0;
    repeat (2) @(negedge mclk);
    chk({cfg.right_x, cfg.left_x}, 32'h0456_0123, "edge scan");
  endtask

  task automatic t_queue();
    logic [1:0] r;
    int n;
    eng_ready = 1'b0;
    for (int i = 0; i < 32; i++) wr(`DSR_OFF_DRAW_COUNT, 32'(i));
    rd(`DSR_OFF_QSTATUS, 32'h0000_0100, "status full");
    host.write(`DSR_OFF_DRAW_COUNT, 32'h0000_0099, r, n);
    chk({30'h0, r}, 32'h2, "write dropped");
    chk(32'(n), 32'(LIMIT), "retries");
    eng_ready = 1'b1;
    repeat (40) @(negedge mclk);
    rd(`DSR_OFF_QSTATUS, 32'h0000_0220, "status drained");
    chk({16'h0, cfg.draw_count}, 32'h0000_001F, "last queued");
    eng_ready = 1'b0;
    for (int i = 0; i < 3; i++) wr(`DSR_OFF_DRAW_COUNT, 32'h0);
    rd(`DSR_OFF_QSTATUS, 32'h0000_001D, "status partial");
    soft_reset = 1'b1;
    repeat (2) @(negedge mclk);
    soft_reset = 1'b0;
    rd(`DSR_OFF_QSTATUS, 32'h0000_0220, "status flushed");
    eng_ready = 1'b1;
  endtask

  task automatic t_interrupts();
    wr(`DSR_OFF_INT_ENABLE, 32'hFFFF_FFFF);
    rd(`DSR_OFF_INT_ENABLE, 32'h0000_0064, "enable bits");
    rd(`DSR_OFF_INT_CLEAR, 32'h0, "clear reads zero");
    pick = 1'b1;
    repeat (8) @(negedge mclk);
    pick = 1'b0;
    chk({31'h0, inta_n}, 32'h0, "pick raises pin");
    wr(`DSR_OFF_INT_CLEAR, 32'h0000_0004);
    chk({31'h0, inta_n}, 32'h1, "pick cleared");
    vtgt = 12'h005;
    vcnt = 12'h005;
    repeat (4) @(negedge mclk);
    vcnt = 12'h000;
    chk({31'h0, inta_n}, 32'h0, "vline raises pin");
    wr(`DSR_OFF_INT_CLEAR, 32'h0000_0020);
    chk({31'h0, inta_n}, 32'h1, "vline cleared");
    ext = 1'b1;
    repeat (8) @(negedge mclk);
    chk({31'h0, inta_n}, 32'h0, "external raises pin");
    ext = 1'b0;
    repeat (8) @(negedge mclk);
    chk({31'h0, inta_n}, 32'h1, "external gone");
    wr(`DSR_OFF_INT_ENABLE, 32'h0);
    pick = 1'b1;
    repeat (8) @(negedge mclk);
    pick = 1'b0;
    chk({31'h0, inta_n}, 32'h1, "masked pick");
  endtask

  initial begin
    nrst = 1'b0;
    soft_reset = 1'b0;
    eng_ready = 1'b1;
    xl_we = 1'b0;
    xr_we = 1'b0;
    xl = 16'h0;
    xr = 16'h0;
    pick = 1'b0;
    ext = 1'b0;
    vcnt = 12'h000;
    vtgt = 12'hFFF;
    err_count = 0;
    check_count = 0;
    cycles = 0;
    pulses = 0;
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    t_reset();
    t_control();
    t_setup();
    t_color();
    t_geometry();
    t_queue();
    t_interrupts();
    summarize();
  end
endmodule
